// File: core/mbs_top.sv
/*
  Memory map and bank select unit: program address forming, banked
  data memory with special registers, peripheral flags, bus slave.
  Assumes core and peripherals run on clk; AXI4-Lite master on clk.
*/
`timescale 1ns/1ps
module mbs_top import mbs_pkg::*; (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Instruction fetch bus
  input wire logic fetch_req,
  input wire logic [PC_W-1:0] fetch_pc,
  input wire logic vector_take,
  output logic [PC_W-1:0] prog_addr_ff,
  // Data bus
  input wire logic dat_req,
  input wire logic dat_we,
  input wire logic dat_ind,
  input wire logic [LOC_W-1:0] dat_addr,
  input wire logic [7:0] dat_wdata,
  output logic [7:0] dat_rdata_ff,
  output logic dat_ack_ff,
  // Peripheral events and core interrupt
  input wire logic [7:0] periph_event,
  output logic core_irq_ff,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt to system
  output logic irq_ff
);
  typedef struct packed {
    logic [PC_W-1:0] prog_addr;
    logic [7:0] status;
    logic [7:0] ptr;
    logic [7:0] intctl;
    logic [7:0] pflag;
    logic [7:0] pen;
    logic [7:0] dat_rdata;
    logic dat_ack;
    logic core_irq;
    logic variant4k;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mbs_top_st_t;

  mbs_top_st_t s_ff;
  mbs_top_st_t nxt_s;

  function automatic logic [PC_W-1:0] mbs_wrap(
    input logic [PC_W-1:0] pc,
    input logic big
  );
    mbs_wrap = pc & (big ? PROG_MASK_4K : PROG_MASK_2K);
  endfunction : mbs_wrap

  // Region of a local bank offset
  function automatic mbs_region_t mbs_region(input logic [LOC_W-1:0] loc);
    if (loc <= SFR_TOP) begin
      mbs_region = RG_SFR;
    end else if (loc >= GPR_BASE && loc <= GPR_TOP) begin
      mbs_region = RG_GPR;
    end else begin
      mbs_region = RG_NONE;
    end
  endfunction : mbs_region

  logic [FULL_W-1:0] dat_full;
  logic [1:0] dat_bank;
  logic [LOC_W-1:0] dat_loc;
  mbs_region_t dat_rg;
  logic [GPR_IDX_W-1:0] gpr_idx;
  logic gpr_wr;
  logic [7:0] gpr_rd;
  logic [7:0] sfr_rd;
  logic [7:0] pf_events;
  logic [ADDR_W-1:0] wr_word;
  logic [ADDR_W-1:0] rd_word;

  always_comb begin
    dat_full = {s_ff.status[BANK_HI_BIT:BANK_LO_BIT], dat_addr};
    if (dat_ind || dat_addr == SFR_INDIRECT) begin
      dat_full = {s_ff.status[IND_BANK_BIT], s_ff.ptr};
    end
    dat_bank = dat_full[FULL_W-1:LOC_W];
    dat_loc = dat_full[LOC_W-1:0];
    dat_rg = mbs_region(dat_loc);
    gpr_idx = {dat_bank, 6'(dat_loc - GPR_BASE)};
    gpr_wr = ce && dat_req && dat_we && dat_rg == RG_GPR;
  end

  mbs_gpr u_gpr (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .wr_en(gpr_wr),
    .wr_idx(gpr_idx),
    .wr_data(dat_wdata),
    .rd_idx(gpr_idx),
    .rd_data(gpr_rd)
  );

  always_comb begin
    sfr_rd = BYTE_RST;
    unique case (dat_loc)
      SFR_STATUS: sfr_rd = s_ff.status;
      SFR_POINTER: sfr_rd = s_ff.ptr;
      SFR_INTCTL: sfr_rd = s_ff.intctl;
      SFR_PERIPH: begin
        if (dat_bank == BANK_FLAGS) begin
          sfr_rd = s_ff.pflag;
        end else if (dat_bank == BANK_ENABLES) begin
          sfr_rd = s_ff.pen;
        end
      end
      default: sfr_rd = BYTE_RST;
    endcase
  end

  assign pf_events = periph_event & PFLAG_IMPL;
  assign wr_word = {s_ff.awaddr[ADDR_W-1:2], 2'b00};
  assign rd_word = {s_axi_araddr[ADDR_W-1:2], 2'b00};

  always_comb begin
    nxt_s = s_ff;
    // fetch path independent of data path
    if (vector_take) begin
      nxt_s.prog_addr = IRQ_VEC;
    end else if (fetch_req) begin
      nxt_s.prog_addr = mbs_wrap(fetch_pc, s_ff.variant4k);
    end

    nxt_s.dat_ack = dat_req;
    if (dat_req && !dat_we) begin
      nxt_s.dat_rdata = (dat_rg == RG_GPR) ? gpr_rd :
                        (dat_rg == RG_SFR) ? sfr_rd : BYTE_RST;
    end
    if (dat_req && dat_we && dat_rg == RG_SFR) begin
      unique case (dat_loc)
        SFR_STATUS: nxt_s.status = dat_wdata;
        SFR_POINTER: nxt_s.ptr = dat_wdata;
        SFR_INTCTL: nxt_s.intctl = dat_wdata;
        SFR_PERIPH: begin
          if (dat_bank == BANK_FLAGS) begin
            nxt_s.pflag = dat_wdata & PFLAG_IMPL;
          end else if (dat_bank == BANK_ENABLES) begin
            nxt_s.pen = dat_wdata & PFLAG_IMPL;
          end
        end
        default: nxt_s.status = s_ff.status;
      endcase
    end
    nxt_s.pflag = nxt_s.pflag | pf_events;
    // software must clear flags before enabling; no guard here
    nxt_s.core_irq = nxt_s.intctl[GLOBAL_IRQ_EN_BIT] &&
                     nxt_s.intctl[PERIPH_IRQ_EN_BIT] &&
                     |(nxt_s.pflag & nxt_s.pen);

    // Bus write: address and data taken in either order
    if (s_axi_awvalid && s_ff.awready) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_ff.wready) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wdata = s_axi_wdata;
      nxt_s.wstrb = s_axi_wstrb;
    end
    if (s_ff.bvalid && s_axi_bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_ff.aw_got && s_ff.w_got && !s_ff.bvalid) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = RESP_OKAY;
      unique case (wr_word)
        ADDR_CTRL: begin
          if (s_ff.wstrb[0]) begin
            nxt_s.variant4k = s_ff.wdata[CTRL_VARIANT_BIT];
          end
        end
        ADDR_IRQ_STAT: begin
          if (s_ff.wstrb[0]) begin
            nxt_s.irq_stat = s_ff.irq_stat & ~s_ff.wdata[IRQ_W-1:0];
          end
        end
        ADDR_IRQ_MASK: begin
          if (s_ff.wstrb[0]) begin
            nxt_s.irq_mask = s_ff.wdata[IRQ_W-1:0];
          end
        end
        ADDR_STATE: nxt_s.bresp = RESP_OKAY;
        default: nxt_s.bresp = RESP_SLVERR;
      endcase
    end
    // Events after the clear so a same-cycle event survives it
    if (fetch_req && !vector_take && fetch_pc != mbs_wrap(fetch_pc,
        s_ff.variant4k)) begin
      nxt_s.irq_stat[EV_WRAP] = 1'b1;
    end
    if (vector_take) begin
      nxt_s.irq_stat[EV_VECTOR] = 1'b1;
    end
    if (|(pf_events & ~s_ff.pflag)) begin
      nxt_s.irq_stat[EV_PFLAG] = 1'b1;
    end
    nxt_s.irq = |(nxt_s.irq_stat & nxt_s.irq_mask);
    nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
    nxt_s.wready = !nxt_s.w_got && !nxt_s.bvalid;

    // Bus read
    if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_ff.arready) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = RESP_OKAY;
      nxt_s.rdata = '0;
      unique case (rd_word)
        ADDR_CTRL: nxt_s.rdata[CTRL_VARIANT_BIT] = s_ff.variant4k;
        ADDR_STATE: nxt_s.rdata = {3'h0, s_ff.prog_addr, s_ff.ptr,
                                   s_ff.status};
        ADDR_IRQ_STAT: nxt_s.rdata[IRQ_W-1:0] = s_ff.irq_stat;
        ADDR_IRQ_MASK: nxt_s.rdata[IRQ_W-1:0] = s_ff.irq_mask;
        default: nxt_s.rresp = RESP_SLVERR;
      endcase
    end
    nxt_s.arready = !nxt_s.rvalid;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_ff <= '0;
      s_ff.prog_addr <= RESET_VEC;
      s_ff.awready <= 1'b1;
      s_ff.wready <= 1'b1;
      s_ff.arready <= 1'b1;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  assign prog_addr_ff = s_ff.prog_addr;
  assign dat_rdata_ff = s_ff.dat_rdata;
  assign dat_ack_ff = s_ff.dat_ack;
  assign core_irq_ff = s_ff.core_irq;
  assign irq_ff = s_ff.irq;
  assign s_axi_awready = s_ff.awready;
  assign s_axi_wready = s_ff.wready;
  assign s_axi_bvalid = s_ff.bvalid;
  assign s_axi_bresp = s_ff.bresp;
  assign s_axi_arready = s_ff.arready;
  assign s_axi_rvalid = s_ff.rvalid;
  assign s_axi_rdata = s_ff.rdata;
  assign s_axi_rresp = s_ff.rresp;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_fetch;
    ce && fetch_req && !vector_take;
  endsequence
  sequence s_vector;
    ce && vector_take;
  endsequence
  sequence s_status_read;
    ce && dat_req && !dat_we && !dat_ind && dat_addr == SFR_STATUS;
  endsequence

  a_reset_fetch: assert property ($past(reset) |->
    prog_addr_ff == RESET_VEC)
    else $error("fetch not at reset vector after reset");
  a_irq_vector: assert property (s_vector |=>
    prog_addr_ff == IRQ_VEC && s_ff.irq_stat[EV_VECTOR])
    else $error("interrupt vector not taken");
  a_pc_wrap: assert property (s_fetch |=>
    prog_addr_ff[10:0] == $past(fetch_pc[10:0]) &&
    prog_addr_ff <= ($past(s_ff.variant4k) ? PROG_MASK_4K : PROG_MASK_2K))
    else $error("program address not wrapped into implemented size");
  a_wrap_flag: assert property (s_fetch ##0 (fetch_pc > PROG_MASK_4K)
    |=> s_ff.irq_stat[EV_WRAP] ##0 prog_addr_ff <= PROG_SPACE_TOP)
    else $error("wrap above 4K not flagged");
  a_dual_bus: assert property (s_fetch ##0 (ce && dat_req) |=>
    dat_ack_ff && prog_addr_ff == mbs_wrap($past(fetch_pc),
    $past(s_ff.variant4k)))
    else $error("fetch and data access did not both complete");
  a_status_mirror: assert property (s_status_read |=>
    dat_rdata_ff == $past(s_ff.status))
    else $error("status not visible from this bank");
  a_direct_bank: assert property (ce && dat_req && !dat_ind &&
    dat_addr != SFR_INDIRECT |-> dat_bank ==
    s_ff.status[BANK_HI_BIT:BANK_LO_BIT] && dat_loc == dat_addr)
    else $error("direct address not formed from bank bits");
  a_unimpl_zero: assert property (ce && dat_req && !dat_we &&
    dat_loc > GPR_TOP |=> dat_rdata_ff == BYTE_RST)
    else $error("unimplemented location not read as zero");
  a_flag_free: assert property (ce && |pf_events |=>
    (s_ff.pflag & $past(pf_events)) == $past(pf_events))
    else $error("peripheral flag not set on its event");
  a_global_gate: assert property (!s_ff.intctl[GLOBAL_IRQ_EN_BIT] &&
    !(ce && dat_req && dat_we) |=> !core_irq_ff)
    else $error("core interrupt raised with global enable low");
  a_ind_status: assert property (ce && dat_req && !dat_we &&
    dat_ind && s_ff.ptr[LOC_W-1:0] == SFR_STATUS |=>
    dat_rdata_ff == $past(s_ff.status))
    else $error("indirect access missed its target");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
endmodule : mbs_top

// File: core/mbs_pkg.sv
/*
  Constants and types for the memory map and bank select block.
  Assumes one 125 MHz clock shared by core, peripherals and bus.
*/
package mbs_pkg;
  // Program side
  localparam int PC_W = 13;
  localparam int INSN_W = 14;
  localparam logic [PC_W-1:0] PROG_SPACE_TOP = 13'h1fff;
  localparam logic [PC_W-1:0] PROG_MASK_2K = 13'h07ff;
  localparam logic [PC_W-1:0] PROG_MASK_4K = 13'h0fff;
  localparam logic [PC_W-1:0] RESET_VEC = 13'h0000;
  localparam logic [PC_W-1:0] IRQ_VEC = 13'h0004;
  // Data side
  localparam int LOC_W = 7;
  localparam int FULL_W = 9;
  localparam int BANK_LO_BIT = 5;
  localparam int BANK_HI_BIT = 6;
  localparam int IND_BANK_BIT = 7;
  localparam logic [LOC_W-1:0] LOCAL_TOP = 7'h7f;
  localparam logic [LOC_W-1:0] SFR_TOP = 7'h1f;
  localparam logic [LOC_W-1:0] GPR_BASE = 7'h20;
  localparam logic [LOC_W-1:0] GPR_TOP = 7'h5f;
  localparam int GPR_IDX_W = 8;
  localparam int GPR_DEPTH = 256;
  localparam logic [LOC_W-1:0] SFR_INDIRECT = 7'h00;
  localparam logic [LOC_W-1:0] SFR_STATUS = 7'h03;
  localparam logic [LOC_W-1:0] SFR_POINTER = 7'h04;
  localparam logic [LOC_W-1:0] SFR_INTCTL = 7'h0b;
  localparam logic [LOC_W-1:0] SFR_PERIPH = 7'h0c;
  localparam logic [1:0] BANK_FLAGS = 2'h0;
  localparam logic [1:0] BANK_ENABLES = 2'h1;
  localparam int GLOBAL_IRQ_EN_BIT = 7;
  localparam int PERIPH_IRQ_EN_BIT = 6;
  localparam logic [7:0] PFLAG_IMPL = 8'h4f;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // Register bus
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CTRL_VARIANT_BIT = 0;
  localparam int IRQ_W = 3;
  localparam int EV_WRAP = 0;
  localparam int EV_VECTOR = 1;
  localparam int EV_PFLAG = 2;
  typedef enum logic [1:0] {
    RG_SFR = 2'b00,
    RG_GPR = 2'b01,
    RG_NONE = 2'b10
  } mbs_region_t;
endpackage : mbs_pkg

// File: core/mbs_gpr.sv
/*
  General purpose static RAM of the data memory, flip-flop storage.
  Assumes the caller has already mapped bank and offset to an index.
*/
`timescale 1ns/1ps
module mbs_gpr import mbs_pkg::*; (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Write port
  input wire logic wr_en,
  input wire logic [GPR_IDX_W-1:0] wr_idx,
  input wire logic [7:0] wr_data,
  // Read port, combinational
  input wire logic [GPR_IDX_W-1:0] rd_idx,
  output logic [7:0] rd_data
);
  typedef struct packed {
    logic [GPR_DEPTH-1:0][7:0] mem;
  } mbs_gpr_st_t;

  mbs_gpr_st_t s_ff;
  mbs_gpr_st_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    if (wr_en) begin
      nxt_s.mem[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_ff <= '0;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  assign rd_data = s_ff.mem[rd_idx];
endmodule : mbs_gpr

// File: dv/mbs_core_model.sv
/*
  Core-side model: issues fetch, vector and data requests.
  Assumes calls come after reset release, on the shared clock.
*/
`timescale 1ns/1ps
module mbs_core_model import mbs_pkg::*; (
  // Clock
  input wire logic clk,
  // Fetch side
  output logic fetch_req,
  output logic [PC_W-1:0] fetch_pc,
  output logic vector_take,
  input wire logic [PC_W-1:0] prog_addr_ff,
  // Data side
  output logic dat_req,
  output logic dat_we,
  output logic dat_ind,
  output logic [LOC_W-1:0] dat_addr,
  output logic [7:0] dat_wdata,
  input wire logic [7:0] dat_rdata_ff,
  input wire logic dat_ack_ff
);
  initial begin
    fetch_req = 1'b0;
    fetch_pc = '0;
    vector_take = 1'b0;
    dat_req = 1'b0;
    dat_we = 1'b0;
    dat_ind = 1'b0;
    dat_addr = '0;
    dat_wdata = '0;
  end

  task automatic fetch(input logic [PC_W-1:0] pc, input logic vec,
                       output logic [PC_W-1:0] pa);
    @(posedge clk);
    fetch_req <= ~vec;
    vector_take <= vec;
    fetch_pc <= pc;
    @(posedge clk);
    fetch_req <= 1'b0;
    vector_take <= 1'b0;
    // Released lines must not keep showing the old value
    fetch_pc <= ~pc;
    #1;
    pa = prog_addr_ff;
  endtask : fetch

  task automatic access(input logic we, input logic ind,
                        input logic [LOC_W-1:0] a, input logic [7:0] wd,
                        output logic [7:0] rd, output logic ack);
    @(posedge clk);
    dat_req <= 1'b1;
    dat_we <= we;
    dat_ind <= ind;
    dat_addr <= a;
    dat_wdata <= wd;
    @(posedge clk);
    dat_req <= 1'b0;
    dat_addr <= ~a;
    dat_wdata <= ~wd;
    #1;
    rd = dat_rdata_ff;
    ack = dat_ack_ff;
  endtask : access
endmodule : mbs_core_model

// File: dv/memory_map_and_bank_select_tb.sv
/*
  Bench for the memory map and bank select unit.
  Assumes the core model drives fetch and data, bench drives the bus.
*/
`timescale 1ns/1ps
module memory_map_and_bank_select_tb import mbs_pkg::*; ;
  logic clk, reset, ce, fetch_req, vector_take, dat_req, dat_we, dat_ind;
  logic [PC_W-1:0] fetch_pc, prog_addr_ff, pa;
  logic [LOC_W-1:0] dat_addr;
  logic [7:0] dat_wdata, dat_rdata_ff, periph_event, rb;
  logic dat_ack_ff, core_irq_ff, irq_ff, ak;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  int mismatches, checks_done;

  mbs_top DUT (.clk(clk), .reset(reset), .ce(ce),
    .fetch_req(fetch_req), .fetch_pc(fetch_pc),
    .vector_take(vector_take), .prog_addr_ff(prog_addr_ff),
    .dat_req(dat_req), .dat_we(dat_we), .dat_ind(dat_ind),
    .dat_addr(dat_addr), .dat_wdata(dat_wdata),
    .dat_rdata_ff(dat_rdata_ff), .dat_ack_ff(dat_ack_ff),
    .periph_event(periph_event), .core_irq_ff(core_irq_ff),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_ff(irq_ff));

  mbs_core_model core (.clk(clk), .fetch_req(fetch_req),
    .fetch_pc(fetch_pc), .vector_take(vector_take),
    .prog_addr_ff(prog_addr_ff), .dat_req(dat_req), .dat_we(dat_we),
    .dat_ind(dat_ind), .dat_addr(dat_addr), .dat_wdata(dat_wdata),
    .dat_rdata_ff(dat_rdata_ff), .dat_ack_ff(dat_ack_ff));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task complete_run;
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic done;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~v;
      end
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_wr

  task axi_rd(input logic [7:0] a);
    logic done;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_rd

  task dacc(input logic we, input logic ind, input logic [6:0] a,
            input logic [7:0] v);
    core.access(we, ind, a, v, rb, ak);
    chk(32'(ak), 32'h1);
  endtask : dacc

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run;
  end

  initial begin
    {reset, ce, periph_event} = {1'b1, 1'b1, 8'h00};
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    mismatches = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    chk(32'(prog_addr_ff), 32'(RESET_VEC));
    core.fetch(13'h1805, 1'b0, pa);
    chk(32'(pa), 32'h0005);
    core.fetch(13'h0010, 1'b1, pa);
    chk(32'(pa), 32'(IRQ_VEC));
    axi_rd(ADDR_IRQ_STAT);
    chk(d, 32'h3);
    chk(32'(irq_ff), 32'h0);
    axi_wr(ADDR_IRQ_MASK, 32'h1);
    chk(32'(r), 32'(RESP_OKAY));
    repeat (2) @(posedge clk);
    chk(32'(irq_ff), 32'h1);
    axi_wr(ADDR_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irq_ff), 32'h0);
    axi_rd(ADDR_IRQ_STAT);
    chk(d, 32'h2);
    axi_wr(ADDR_CTRL, 32'h1);
    core.fetch(13'h1805, 1'b0, pa);
    chk(32'(pa), 32'h0805);
    core.fetch(PROG_SPACE_TOP, 1'b0, pa);
    chk(32'(pa), 32'h0fff);
    axi_rd(8'h10);
    chk(32'(r), 32'(RESP_SLVERR));
    chk(d, 32'h0);
    axi_wr(8'h10, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR));
    // Same general purpose offsets in every bank must land in distinct storage
    for (int b = 0; b < 4; b++) begin
      dacc(1'b1, 1'b0, SFR_STATUS, 8'(b << 5));
      dacc(1'b1, 1'b0, GPR_BASE, 8'ha0 + 8'(b));
      dacc(1'b1, 1'b0, GPR_TOP, 8'hb0 + 8'(b));
    end
    for (int b = 0; b < 4; b++) begin
      dacc(1'b1, 1'b0, SFR_STATUS, 8'(b << 5));
      dacc(1'b0, 1'b0, GPR_BASE, 8'h00);
      chk(32'(rb), 32'(8'ha0 + 8'(b)));
      dacc(1'b0, 1'b0, GPR_TOP, 8'h00);
      chk(32'(rb), 32'(8'hb0 + 8'(b)));
      dacc(1'b0, 1'b0, SFR_STATUS, 8'h00);
      chk(32'(rb & 8'he0), 32'(b << 5));
      dacc(1'b0, 1'b0, LOCAL_TOP, 8'h00);
      chk(32'(rb), 32'h0);
    end
    dacc(1'b1, 1'b0, SFR_POINTER, 8'ha0);
    dacc(1'b0, 1'b1, 7'h00, 8'h00);
    chk(32'(rb), 32'ha1);
    dacc(1'b1, 1'b0, 7'h00, 8'h5c);
    dacc(1'b1, 1'b0, SFR_STATUS, 8'h20);
    dacc(1'b0, 1'b0, GPR_BASE, 8'h00);
    chk(32'(rb), 32'h5c);
    axi_rd(ADDR_STATE);
    chk(d & 32'hffffffe0, 32'h0fffa020);
    // Pointer aimed at the status offset reaches the mirrored status
    dacc(1'b1, 1'b0, SFR_POINTER, 8'h03);
    dacc(1'b0, 1'b1, 7'h00, 8'h00);
    chk(32'(rb), 32'h20);
    fork
      core.fetch(13'h0123, 1'b0, pa);
      dacc(1'b0, 1'b0, GPR_BASE, 8'h00);
    join
    chk(32'(pa), 32'h0123);
    chk(32'(rb), 32'h5c);
    // Enable low must freeze the program address
    @(posedge clk);
    ce <= 1'b0;
    core.fetch(13'h0055, 1'b0, pa);
    chk(32'(pa), 32'h0123);
    @(posedge clk);
    ce <= 1'b1;
    dacc(1'b1, 1'b0, SFR_STATUS, 8'h00);
    @(posedge clk);
    periph_event <= 8'hff;
    @(posedge clk);
    periph_event <= 8'h00;
    dacc(1'b0, 1'b0, SFR_PERIPH, 8'h00);
    chk(32'(rb), 32'(PFLAG_IMPL));
    chk(32'(core_irq_ff), 32'h0);
    dacc(1'b1, 1'b0, SFR_PERIPH, 8'h00);
    dacc(1'b0, 1'b0, SFR_PERIPH, 8'h00);
    chk(32'(rb), 32'h0);
    dacc(1'b1, 1'b0, SFR_INTCTL, 8'hc0);
    dacc(1'b1, 1'b0, SFR_STATUS, 8'h20);
    dacc(1'b1, 1'b0, SFR_PERIPH, 8'h01);
    chk(32'(core_irq_ff), 32'h0);
    @(posedge clk);
    periph_event <= 8'h01;
    @(posedge clk);
    periph_event <= 8'h00;
    repeat (3) @(posedge clk);
    chk(32'(core_irq_ff), 32'h1);
    complete_run;
  end
endmodule : memory_map_and_bank_select_tb
